// ---- pkg/pesf_pkg.sv ----
`default_nettype none
package pesf_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-3:0] IDX_STATUS = 18'h0e503;
  localparam logic [ADDR_W-3:0] IDX_MASK   = 18'h0e504;
  localparam logic [ADDR_W-3:0] IDX_NOLOAD = 18'h0e505;
  localparam logic [ADDR_W-3:0] IDX_PHASE  = 18'h0e506;
  localparam logic [ADDR_W-3:0] IDX_SETUP  = 18'h0e507;
  // Event status bit positions
  localparam int unsigned NUM_FLAGS        = 18;
  localparam int unsigned BIT_TOTAL_NOLOAD = 0;
  localparam int unsigned BIT_FUND_NOLOAD  = 1;
  localparam int unsigned BIT_APP_NOLOAD   = 2;
  localparam int unsigned BIT_VOLT_TIMEOUT = 3;
  localparam int unsigned BIT_CURR_TIMEOUT = 6;
  localparam int unsigned BIT_VOLT_SEEN    = 9;
  localparam int unsigned BIT_CURR_SEEN    = 12;
  localparam int unsigned BIT_RESET_DONE   = 15;
  localparam int unsigned BIT_SAG          = 16;
  localparam int unsigned BIT_OVERCURRENT  = 17;
  // Phase field positions and the soft reset bit
  localparam int unsigned LSB_TOTAL_PHASE  = 0;
  localparam int unsigned LSB_FUND_PHASE   = 3;
  localparam int unsigned LSB_APP_PHASE    = 6;
  localparam int unsigned LSB_OC_PHASE     = 3;
  localparam int unsigned LSB_SAG_PHASE    = 12;
  localparam int unsigned BIT_SOFT_RESET   = 7;
  // Reset values
  localparam logic [NUM_FLAGS-1:0] STATUS_RESET = 18'h00000;
  localparam logic [NUM_FLAGS-1:0] MASK_RESET   = 18'h00000;
  localparam logic [8:0]           NOLOAD_RESET = 9'h000;
  localparam logic [2:0]           PHASE_RESET  = 3'h0;
  // Timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned RST_SETTLE_NS  = 1000;
  localparam int unsigned RST_SETTLE_CYC = (RST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    PESF_SEL_NONE   = 3'b000,
    PESF_SEL_STATUS = 3'b001,
    PESF_SEL_MASK   = 3'b010,
    PESF_SEL_NOLOAD = 3'b011,
    PESF_SEL_PHASE  = 3'b100,
    PESF_SEL_SETUP  = 3'b101
  } pesf_sel_t;

  typedef enum logic [1:0] {
    NORMAL_POWER_MODE  = 2'b00,
    REDUCED_POWER_MODE = 2'b01,
    LOW_POWER_MODE     = 2'b10,
    SLEEP_MODE         = 2'b11
  } pesf_power_mode_t;

  function automatic pesf_sel_t pesf_decode(input logic [ADDR_W-1:0] addr);
    pesf_sel_t sel;
    sel = PESF_SEL_NONE;
    if (addr[1:0] == 2'b00) begin
      case (addr[ADDR_W-1:2])
        IDX_STATUS: sel = PESF_SEL_STATUS;
        IDX_MASK:   sel = PESF_SEL_MASK;
        IDX_NOLOAD: sel = PESF_SEL_NOLOAD;
        IDX_PHASE:  sel = PESF_SEL_PHASE;
        IDX_SETUP:  sel = PESF_SEL_SETUP;
        default:    sel = PESF_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  function automatic logic [DATA_W-1:0] pesf_strb_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction
endpackage
`default_nettype wire

// ---- hdl/pesf_sticky.sv ----
`timescale 1ns/1ps
`default_nettype none
module pesf_sticky #(
  parameter int unsigned WIDTH = pesf_pkg::NUM_FLAGS
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Control
  input  wire logic             init,
  input  wire logic [WIDTH-1:0] set,
  input  wire logic [WIDTH-1:0] clr,
  // Flags
  output logic      [WIDTH-1:0] flags
);
  import pesf_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } pesf_sticky_t;

  pesf_sticky_t st;
  pesf_sticky_t next_st;

  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    next_st = st;
    if (init) begin
      next_st.flags = WIDTH'(STATUS_RESET);
    end else begin
      next_st.flags = (st.flags & ~clr) | set; // R12
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flags = st.flags;
endmodule
`default_nettype wire

// ---- hdl/pesf_reset_seq.sv ----
`timescale 1ns/1ps
`default_nettype none
module pesf_reset_seq #(
  parameter int unsigned SETTLE_CYC = pesf_pkg::RST_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // Reset sources
  input  wire logic                       soft_reset_req,
  input  wire pesf_pkg::pesf_power_mode_t power_mode,
  // Sequencer state
  output logic                            busy,
  output logic                            done
);
  import pesf_pkg::*;

  localparam int unsigned CW = $clog2(SETTLE_CYC + 1);

  typedef enum logic [0:0] {
    SEQ_IDLE   = 1'b0,
    SEQ_SETTLE = 1'b1
  } pesf_seq_state_t;

  typedef struct packed {
    pesf_seq_state_t  state;
    logic [CW-1:0]    cnt;
    logic             done;
    pesf_power_mode_t prev_mode;
  } pesf_seq_t;

  pesf_seq_t st;
  pesf_seq_t next_st;

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.prev_mode = power_mode;
    case (st.state)
      SEQ_IDLE: begin
        // Leaving any saving mode for normal mode restores defaults too
        if (soft_reset_req ||
            (st.prev_mode != NORMAL_POWER_MODE && power_mode == NORMAL_POWER_MODE)) begin
          next_st.state = SEQ_SETTLE; // R8
          next_st.cnt = '0;
        end
      end
      SEQ_SETTLE: begin
        if (st.cnt == CW'(SETTLE_CYC - 1)) begin
          next_st.state = SEQ_IDLE;
          next_st.done = 1'b1; // R8
        end else begin
          next_st.cnt = st.cnt + 1'b1;
        end
      end
      default: begin
        next_st.state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '{state: SEQ_SETTLE, cnt: '0, done: 1'b0, prev_mode: NORMAL_POWER_MODE};
    end else begin
      st <= next_st;
    end
  end

  assign busy = (st.state == SEQ_SETTLE);
  assign done = st.done;
endmodule
`default_nettype wire

// ---- hdl/pesf_event_status.sv ----
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: Total-power no-load sets bit 0, phase bits 2:0
// R2: Fundamental no-load sets bit 1, phase bits 5:3
// R3: Apparent no-load sets bit 2, phase bits 8:6
// R4: Missing voltage crossing sets bits 3 to 5
// R5: Missing current crossing sets bits 6 to 8
// R6: Voltage crossing seen sets bits 9 to 11
// R7: Current crossing seen sets bits 12 to 14
// R8: Any reset completion sets bit 15
// R9: Reset-complete flag drives line low, unmaskable
// R10: Sag sets bit 16, phases in bits 14:12
// R11: Overcurrent sets bit 17, phases in bits 5:3
// R12: Write one clears a flag; zero leaves it
module pesf_event_status #(
  parameter int unsigned SETTLE_CYC = pesf_pkg::RST_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // AXI4-Lite write address
  input  wire logic [pesf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [pesf_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]                  s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [pesf_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  // AXI4-Lite read data
  output logic      [pesf_pkg::DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]                  s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // No-load events
  input  wire logic                        total_noload_event,
  input  wire logic [2:0]                  total_noload_phase,
  input  wire logic                        fund_noload_event,
  input  wire logic [2:0]                  fund_noload_phase,
  input  wire logic                        apparent_noload_event,
  input  wire logic [2:0]                  apparent_noload_phase,
  // Zero crossing events, bit 0 is phase A
  input  wire logic [2:0]                  volt_crossing_timeout,
  input  wire logic [2:0]                  curr_crossing_timeout,
  input  wire logic [2:0]                  volt_crossing_seen,
  input  wire logic [2:0]                  curr_crossing_seen,
  // Sag and overcurrent events
  input  wire logic                        sag_event,
  input  wire logic [2:0]                  sag_phase,
  input  wire logic                        overcurrent_event,
  input  wire logic [2:0]                  overcurrent_phase,
  // Power mode
  input  wire pesf_pkg::pesf_power_mode_t  power_mode,
  // Interrupts
  output logic                             irq,
  output logic                             interrupt_line_one_n
);
  import pesf_pkg::*;

  typedef struct packed {
    logic                 aw_full;
    logic [ADDR_W-1:0]    aw_addr;
    logic                 w_full;
    logic [DATA_W-1:0]    w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [DATA_W-1:0]    rdata;
    logic [NUM_FLAGS-1:0] mask;
    logic [8:0]           noload_phase;
    logic [2:0]           sag_phase;
    logic [2:0]           oc_phase;
  } pesf_regs_t;

  pesf_regs_t           st;
  pesf_regs_t           next_st;
  pesf_sel_t            wr_sel;
  pesf_sel_t            rd_sel;
  logic                 wr_go;
  logic [DATA_W-1:0]    wr_smask;
  logic [DATA_W-1:0]    wr_bits;
  logic [NUM_FLAGS-1:0] status;
  logic [NUM_FLAGS-1:0] status_set;
  logic [NUM_FLAGS-1:0] status_clr;
  logic [NUM_FLAGS-1:0] mask_view;
  logic [15:0]          phase_view;
  logic [DATA_W-1:0]    rd_word;
  logic                 soft_reset_req;
  logic                 seq_busy;
  logic                 seq_done;
  logic                 ev_live;

  // Write commits once address and data have both been taken
  assign wr_sel   = pesf_decode(st.aw_addr);
  assign rd_sel   = pesf_decode(s_axi_araddr);
  assign wr_go    = st.aw_full && st.w_full && !st.bvalid;
  assign wr_smask = pesf_strb_mask(st.w_strb);
  assign wr_bits  = st.w_data & wr_smask;

  // Events are dropped while defaults are being restored
  assign ev_live = !seq_busy;

  assign status_set[BIT_TOTAL_NOLOAD]    = ev_live && total_noload_event; // R1
  assign status_set[BIT_FUND_NOLOAD]     = ev_live && fund_noload_event; // R2
  assign status_set[BIT_APP_NOLOAD]      = ev_live && apparent_noload_event; // R3
  assign status_set[BIT_VOLT_TIMEOUT+:3] = ev_live ? volt_crossing_timeout : 3'h0; // R4
  assign status_set[BIT_CURR_TIMEOUT+:3] = ev_live ? curr_crossing_timeout : 3'h0; // R5
  assign status_set[BIT_VOLT_SEEN+:3]    = ev_live ? volt_crossing_seen : 3'h0; // R6
  assign status_set[BIT_CURR_SEEN+:3]    = ev_live ? curr_crossing_seen : 3'h0; // R7
  assign status_set[BIT_RESET_DONE]      = seq_done; // R8
  assign status_set[BIT_SAG]             = ev_live && sag_event; // R10
  assign status_set[BIT_OVERCURRENT]     = ev_live && overcurrent_event; // R11

  assign status_clr = (wr_go && wr_sel == PESF_SEL_STATUS) ? wr_bits[NUM_FLAGS-1:0] : '0; // R12
  assign soft_reset_req = wr_go && wr_sel == PESF_SEL_SETUP && wr_bits[BIT_SOFT_RESET]; // R8

  pesf_sticky #(
    .WIDTH (NUM_FLAGS)
  ) u_sticky (
    .aclk    (aclk),
    .aresetn (aresetn),
    .init    (seq_busy),
    .set     (status_set),
    .clr     (status_clr),
    .flags   (status)
  );

  pesf_reset_seq #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_seq (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .soft_reset_req (soft_reset_req),
    .power_mode     (power_mode),
    .busy           (seq_busy),
    .done           (seq_done)
  );

  // Reset-complete cannot be masked, so its mask bit reads one
  assign mask_view  = st.mask | (NUM_FLAGS'(1) << BIT_RESET_DONE); // R9
  assign phase_view = (16'(st.sag_phase) << LSB_SAG_PHASE) | (16'(st.oc_phase) << LSB_OC_PHASE);

  always_comb begin
    case (rd_sel)
      PESF_SEL_STATUS: rd_word = DATA_W'(status);
      PESF_SEL_MASK:   rd_word = DATA_W'(mask_view);
      PESF_SEL_NOLOAD: rd_word = DATA_W'(st.noload_phase);
      PESF_SEL_PHASE:  rd_word = DATA_W'(phase_view);
      default:         rd_word = '0;
    endcase
  end

  always_comb begin
    next_st = st;
    // Bus channels
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_full = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end
    if (wr_go) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = (wr_sel == PESF_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = (rd_sel == PESF_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Register contents
    if (seq_busy) begin
      next_st.mask         = MASK_RESET;
      next_st.noload_phase = NOLOAD_RESET;
      next_st.sag_phase    = PHASE_RESET;
      next_st.oc_phase     = PHASE_RESET;
    end else begin
      if (wr_go && wr_sel == PESF_SEL_MASK) begin
        next_st.mask = (st.mask & ~wr_smask[NUM_FLAGS-1:0]) | wr_bits[NUM_FLAGS-1:0];
      end
      // Each new event overwrites its phase field with the latest phases
      if (total_noload_event) begin
        next_st.noload_phase[LSB_TOTAL_PHASE+:3] = total_noload_phase; // R1
      end
      if (fund_noload_event) begin
        next_st.noload_phase[LSB_FUND_PHASE+:3] = fund_noload_phase; // R2
      end
      if (apparent_noload_event) begin
        next_st.noload_phase[LSB_APP_PHASE+:3] = apparent_noload_phase; // R3
      end
      if (sag_event) begin
        next_st.sag_phase = sag_phase; // R10
      end
      if (overcurrent_event) begin
        next_st.oc_phase = overcurrent_phase; // R11
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // One write and one read at a time keeps the slave free of queues
  assign s_axi_awready = !st.aw_full && !st.bvalid;
  assign s_axi_wready  = !st.w_full && !st.bvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = st.rdata;
  assign s_axi_rresp   = st.rresp;

  assign irq = |(status & mask_view); // R9
  assign interrupt_line_one_n = !irq; // R9

  default clocking pesf_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_TOTAL_NOLOAD: assert property ( // R1
    total_noload_event && !seq_busy |=> status[BIT_TOTAL_NOLOAD] &&
      st.noload_phase[LSB_TOTAL_PHASE+:3] == $past(total_noload_phase))
    else $error("total no-load flag or phase not captured");

  AST_FUND_NOLOAD: assert property ( // R2
    fund_noload_event && !seq_busy |=> status[BIT_FUND_NOLOAD] &&
      st.noload_phase[LSB_FUND_PHASE+:3] == $past(fund_noload_phase))
    else $error("fundamental no-load flag or phase not captured");

  AST_APP_NOLOAD: assert property ( // R3
    apparent_noload_event && !seq_busy |=> status[BIT_APP_NOLOAD] &&
      st.noload_phase[LSB_APP_PHASE+:3] == $past(apparent_noload_phase))
    else $error("apparent no-load flag or phase not captured");

  AST_VOLT_TIMEOUT: assert property ( // R4
    (|volt_crossing_timeout) && !seq_busy |=>
      (status[BIT_VOLT_TIMEOUT+:3] & $past(volt_crossing_timeout)) == $past(volt_crossing_timeout))
    else $error("voltage crossing timeout flag missed");

  AST_CURR_TIMEOUT: assert property ( // R5
    (|curr_crossing_timeout) && !seq_busy |=>
      (status[BIT_CURR_TIMEOUT+:3] & $past(curr_crossing_timeout)) == $past(curr_crossing_timeout))
    else $error("current crossing timeout flag missed");

  AST_VOLT_SEEN: assert property ( // R6
    volt_crossing_seen[2] && !seq_busy |=> status[BIT_VOLT_SEEN + 2])
    else $error("phase C voltage crossing flag missed");

  AST_CURR_SEEN: assert property ( // R7
    curr_crossing_seen[0] && !seq_busy |=> status[BIT_CURR_SEEN])
    else $error("phase A current crossing flag missed");

  AST_RESET_DONE: assert property ( // R8
    $fell(seq_busy) |=> status[BIT_RESET_DONE])
    else $error("reset complete flag not set when defaults restored");

  AST_LINE_LOW: assert property ( // R9
    status[BIT_RESET_DONE] |-> !interrupt_line_one_n && irq)
    else $error("reset complete did not pull the interrupt line low");

  AST_SAG: assert property ( // R10
    sag_event && !seq_busy |=> status[BIT_SAG] && st.sag_phase == $past(sag_phase))
    else $error("sag flag or phases not captured");

  AST_OVERCURRENT: assert property ( // R11
    overcurrent_event && !seq_busy |=> status[BIT_OVERCURRENT] &&
      st.oc_phase == $past(overcurrent_phase))
    else $error("overcurrent flag or phases not captured");

  AST_W1C: assert property ( // R12
    status_clr[BIT_SAG] && !status_set[BIT_SAG] && !seq_busy |=> !status[BIT_SAG])
    else $error("write one did not clear the sag flag");

  AST_STICKY: assert property ( // R12
    status[BIT_OVERCURRENT] && !status_clr[BIT_OVERCURRENT] && !seq_busy
      |=> status[BIT_OVERCURRENT])
    else $error("overcurrent flag dropped without a clear");

  COV_CLEAR_WRITE: cover property (wr_go && status_clr != '0);
  COV_SET_OVER_CLEAR: cover property (status_clr[BIT_SAG] && status_set[BIT_SAG]);
  COV_SOFT_RESET: cover property (soft_reset_req ##[1:40] seq_done);
  COV_UNMAPPED_READ: cover property (st.rvalid && st.rresp == RESP_SLVERR);
endmodule
`default_nettype wire

// ---- tb/pesf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pesf_host_model (
  // Clock
  input  wire logic                        aclk,
  // Write channels
  output logic      [pesf_pkg::ADDR_W-1:0] awaddr,
  output logic                             awvalid,
  input  wire logic                        awready,
  output logic      [pesf_pkg::DATA_W-1:0] wdata,
  output logic      [3:0]                  wstrb,
  output logic                             wvalid,
  input  wire logic                        wready,
  input  wire logic [1:0]                  bresp,
  input  wire logic                        bvalid,
  output logic                             bready,
  // Read channels
  output logic      [pesf_pkg::ADDR_W-1:0] araddr,
  output logic                             arvalid,
  input  wire logic                        arready,
  input  wire logic [pesf_pkg::DATA_W-1:0] rdata,
  input  wire logic [1:0]                  rresp,
  input  wire logic                        rvalid,
  output logic                             rready
);
  import pesf_pkg::*;

  // Response ready held high: legal and avoids a toggle between back-to-back calls
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
    bready = 1'b1;
    rready = 1'b1;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (aw_done && w_done && bvalid) begin
        r = bresp;
        break;
      end
      // Released lines show garbage, not the last value
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr  <= ~a;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
endmodule
`default_nettype wire

// ---- tb/phase_event_status_flags_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module phase_event_status_flags_test;
  import pesf_pkg::*;
  localparam int unsigned         SETTLE = 2;
  localparam logic [ADDR_W-1:0]   A_ST   = {IDX_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0]   A_MK   = {IDX_MASK, 2'b00};
  localparam logic [ADDR_W-1:0]   A_NL   = {IDX_NOLOAD, 2'b00};
  localparam logic [ADDR_W-1:0]   A_PH   = {IDX_PHASE, 2'b00};
  localparam logic [ADDR_W-1:0]   A_SU   = {IDX_SETUP, 2'b00};
  logic                           aclk;
  logic                           aresetn;
  logic [ADDR_W-1:0]              awaddr;
  logic [ADDR_W-1:0]              araddr;
  logic [DATA_W-1:0]              wdata;
  logic [DATA_W-1:0]              rdata;
  logic [3:0]                     wstrb;
  logic [1:0]                     bresp;
  logic [1:0]                     rresp;
  logic                           awvalid, awready, wvalid, wready, bvalid, bready;
  logic                           arvalid, arready, rvalid, rready;
  logic [17:0]                    ev;
  logic [14:0]                    ph;
  pesf_power_mode_t               pm;
  logic                           irq;
  logic                           line_n;
  int                             err_count;
  int                             checks_done;

  pesf_event_status #(.SETTLE_CYC(SETTLE)) i_pesf_event_status (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .total_noload_event(ev[0]), .total_noload_phase(ph[2:0]),
    .fund_noload_event(ev[1]), .fund_noload_phase(ph[5:3]),
    .apparent_noload_event(ev[2]), .apparent_noload_phase(ph[8:6]),
    .volt_crossing_timeout(ev[5:3]), .curr_crossing_timeout(ev[8:6]),
    .volt_crossing_seen(ev[11:9]), .curr_crossing_seen(ev[14:12]),
    .sag_event(ev[16]), .sag_phase(ph[11:9]),
    .overcurrent_event(ev[17]), .overcurrent_phase(ph[14:12]),
    .power_mode(pm), .irq(irq), .interrupt_line_one_n(line_n)
  );

  pesf_host_model i_pesf_host_model (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    i_pesf_host_model.rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic wrc(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    logic [1:0] r;
    i_pesf_host_model.wr(a, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // Interrupt lines sampled mid-cycle, away from the edge where they change
  task automatic chk_line(input logic exp_n);
    @(negedge aclk);
    chk({30'h0, irq, line_n}, {30'h0, ~exp_n, exp_n});
    @(posedge aclk);
  endtask

  // One-cycle event pulse, then one edge for the flag to land
  task automatic pulse(input logic [17:0] e);
    ev <= e;
    @(posedge aclk);
    ev <= '0;
    @(posedge aclk);
  endtask

  task automatic t_reset_done;
    repeat (SETTLE + 4) @(posedge aclk);
    chk_line(1'b0);
    rdc(A_ST, 32'h0000_8000);
    rdc(A_MK, 32'h0000_8000);
    wrc(A_ST, 32'h0000_8000);
    chk_line(1'b1);
    rdc(A_ST, 32'h0000_0000);
  endtask

  task automatic t_crossings;
    for (int i = 3; i < 15; i++) begin
      pulse(18'h1 << i);
      rdc(A_ST, 32'h1 << i);
      wrc(A_ST, ~(32'h1 << i));
      rdc(A_ST, 32'h1 << i);
      wrc(A_ST, 32'h1 << i);
      rdc(A_ST, 32'h0);
    end
  endtask

  task automatic t_phase_fields;
    ph <= {3'h3, 3'h5, 3'h4, 3'h2, 3'h1};
    pulse(18'h30007);
    rdc(A_ST, 32'h0003_0007);
    rdc(A_NL, 32'h0000_0111);
    rdc(A_PH, 32'h0000_5018);
    wrc(A_ST, 32'h0003_0007);
    rdc(A_ST, 32'h0);
  endtask

  task automatic t_irq_mask;
    wrc(A_MK, 32'h0000_0008);
    pulse(18'h40);
    chk_line(1'b1);
    pulse(18'h8);
    chk_line(1'b0);
    wrc(A_ST, 32'h0000_0048);
    chk_line(1'b1);
  endtask

  task automatic t_unmapped;
    rdc(20'h00010, 32'h0, RESP_SLVERR);
    wrc(20'h00010, 32'hffff_ffff, RESP_SLVERR);
  endtask

  // All three restore paths (soft reset, power mode, hardware reset) must end with only the completion flag set
  task automatic t_restore;
    pulse(18'h200);
    wrc(A_SU, 32'h0000_0080);
    repeat (SETTLE + 4) @(posedge aclk);
    rdc(A_ST, 32'h0000_8000);
    rdc(A_MK, 32'h0000_8000);
    // Every saving mode returning to normal restores defaults
    for (int m = 1; m < 4; m++) begin
      wrc(A_ST, 32'h0000_8000);
      pulse(18'h1000);
      pm <= pesf_power_mode_t'(m);
      repeat (3) @(posedge aclk);
      pm <= NORMAL_POWER_MODE;
      repeat (SETTLE + 4) @(posedge aclk);
      rdc(A_ST, 32'h0000_8000);
    end
    chk_line(1'b0);
    // Hardware reset in mid-run ends the same way
    pulse(18'h1000);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (SETTLE + 4) @(posedge aclk);
    rdc(A_ST, 32'h0000_8000);
  endtask

  initial begin
    err_count   = 0;
    checks_done = 0;
    aresetn     = 1'b0;
    ev          = '0;
    ph          = '0;
    pm          = NORMAL_POWER_MODE;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_done();
    t_crossings();
    t_phase_fields();
    t_irq_mask();
    t_unmapped();
    t_restore();
    results();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge aclk);
    err_count++;
    results();
  end
endmodule
`default_nettype wire
